// >>> ttr_pkg.sv
// Purpose: constants for the temperature threshold register bank
// Assumes: 8-bit register port with byte offsets as printed
// Notes:   readings and limits are unsigned, one degree per lsb
// ---------------------------------------------------------------
// Overview of operation
// - alarm when remote 1 exceeds limit 0eh
// - alarm when remote 2 exceeds limit 0fh
// - both critical limits reset to 50h, writable
// - register 10h is internal fan start temp
// - register 12h is remote 2 fan start
// - internal fan start resets to 28h
// - remote fan starts 11h, 12h reset 40h
// ---------------------------------------------------------------
package ttr_pkg;
   localparam logic [7:0] ADDR_R1_CRIT   = 8'h0e;
   localparam logic [7:0] ADDR_R2_CRIT   = 8'h0f;
   localparam logic [7:0] ADDR_INT_START = 8'h10;
   localparam logic [7:0] ADDR_R1_START  = 8'h11;
   localparam logic [7:0] ADDR_R2_START  = 8'h12;
   localparam logic [7:0] RST_CRIT       = 8'h50;
   localparam logic [7:0] RST_INT_START  = 8'h28;
   localparam logic [7:0] RST_REM_START  = 8'h40;
endpackage

// >>> ttr_cmp.sv
// Purpose: strictly-greater temperature compare
// Assumes: unsigned operands
// Notes:   shared by alarm and fan start decisions
`timescale 1ns/1ps
module ttr_cmp #(
   parameter int W = 8
) (
   // operands
   input  wire logic [W-1:0] i_temp,
   input  wire logic [W-1:0] i_limit,
   // result
   output logic              o_above
);
   assign o_above = (i_temp > i_limit);
endmodule

// >>> ttr_regs.sv
// Purpose: threshold registers, critical alarm and fan start flags
// Assumes: register port driven synchronously to i_clk by the bus slave
// Notes:   readings come from logic on the same clock, no synchronisers
`timescale 1ns/1ps
module ttr_regs (
   // clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   // register port
   input  wire logic [7:0] i_addr,
   input  wire logic       i_wr,
   input  wire logic [7:0] i_wdata,
   output logic      [7:0] o_rdata,
   output logic            o_hit,
   // temperature readings
   input  wire logic [7:0] i_temp_int,
   input  wire logic [7:0] i_temp_rd1,
   input  wire logic [7:0] i_temp_rd2,
   // outputs to alarm driver and fan control
   output logic            o_thermal_alarm_out,
   output logic            o_fan_start_int,
   output logic            o_fan_start_rd1,
   output logic            o_fan_start_rd2
);
   typedef struct packed {
      logic       live;
      logic [7:0] crit1;
      logic [7:0] crit2;
      logic [7:0] start_int;
      logic [7:0] start_rd1;
      logic [7:0] start_rd2;
      logic [7:0] rdata;
      logic       hit;
      logic       alarm;
      logic [2:0] fan;
   } ttr_state_s;

   ttr_state_s s_q;
   ttr_state_s s_d;
   logic       rst_n;
   logic       rst_sync_q1;
   logic       rst_sync_q2;
   logic [4:0] above;
   logic [4:0] sel;
   logic [7:0] cmp_temp  [5];
   logic [7:0] cmp_limit [5];

   // ---------------------------------------------------------------
   // reset release
   // ---------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_sync_q1 <= 1'b0;
         rst_sync_q2 <= 1'b0;
      end else begin
         rst_sync_q1 <= 1'b1;
         rst_sync_q2 <= rst_sync_q1;
      end
   end
   assign rst_n = rst_sync_q2;

   // ---------------------------------------------------------------
   // offset decode
   // ---------------------------------------------------------------
   // one-hot select; shared by the write path and the checks
   function automatic logic [4:0] reg_sel(input logic [7:0] a);
      logic [4:0] hot;
      hot    = 5'h00;
      hot[0] = (a == ttr_pkg::ADDR_R1_CRIT);
      hot[1] = (a == ttr_pkg::ADDR_R2_CRIT);
      hot[2] = (a == ttr_pkg::ADDR_INT_START);
      hot[3] = (a == ttr_pkg::ADDR_R1_START);
      hot[4] = (a == ttr_pkg::ADDR_R2_START);
      return hot;
   endfunction

   assign sel = reg_sel(i_addr);

   // ---------------------------------------------------------------
   // comparators
   // ---------------------------------------------------------------
   // slots 0 and 1 feed the alarm, slots 2 to 4 the fan start flags
   assign cmp_temp[0]  = i_temp_rd1;
   assign cmp_limit[0] = s_q.crit1;
   assign cmp_temp[1]  = i_temp_rd2;
   assign cmp_limit[1] = s_q.crit2;
   assign cmp_temp[2]  = i_temp_int;
   assign cmp_limit[2] = s_q.start_int;
   assign cmp_temp[3]  = i_temp_rd1;
   assign cmp_limit[3] = s_q.start_rd1;
   assign cmp_temp[4]  = i_temp_rd2;
   assign cmp_limit[4] = s_q.start_rd2;

   for (genvar g = 0; g < 5; g++) begin : g_cmp
      ttr_cmp #(
         .W (8)
      ) u_cmp (
         .i_temp  (cmp_temp[g]),
         .i_limit (cmp_limit[g]),
         .o_above (above[g])
      );
   end

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      s_d          = s_q;
      // checks wait one edge past release, until outputs are registered again
      s_d.live     = 1'b1;
      s_d.hit      = 1'b1;
      unique case (i_addr)
         ttr_pkg::ADDR_R1_CRIT:   s_d.rdata = s_q.crit1;
         ttr_pkg::ADDR_R2_CRIT:   s_d.rdata = s_q.crit2;
         ttr_pkg::ADDR_INT_START: s_d.rdata = s_q.start_int;
         ttr_pkg::ADDR_R1_START:  s_d.rdata = s_q.start_rd1;
         ttr_pkg::ADDR_R2_START:  s_d.rdata = s_q.start_rd2;
         default: begin
            // unmapped offsets read zero and flag a miss
            s_d.rdata = 8'h00;
            s_d.hit   = 1'b0;
         end
      endcase
      if (i_wr) begin
         if (sel[0]) s_d.crit1     = i_wdata;
         if (sel[1]) s_d.crit2     = i_wdata;
         if (sel[2]) s_d.start_int = i_wdata;
         if (sel[3]) s_d.start_rd1 = i_wdata;
         if (sel[4]) s_d.start_rd2 = i_wdata;
      end
      s_d.alarm = above[0] | above[1];
      s_d.fan   = above[4:2];
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q           <= '0;
         s_q.crit1     <= ttr_pkg::RST_CRIT;
         s_q.crit2     <= ttr_pkg::RST_CRIT;
         s_q.start_int <= ttr_pkg::RST_INT_START;
         s_q.start_rd1 <= ttr_pkg::RST_REM_START;
         s_q.start_rd2 <= ttr_pkg::RST_REM_START;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_rdata             = s_q.rdata;
   assign o_hit               = s_q.hit;
   assign o_thermal_alarm_out = s_q.alarm;
   assign o_fan_start_int     = s_q.fan[0];
   assign o_fan_start_rd1     = s_q.fan[1];
   assign o_fan_start_rd2     = s_q.fan[2];

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   alarm_rd1_a: assert property (@(posedge i_clk) disable iff (!s_q.live)
      (i_temp_rd1 > s_q.crit1) |=> o_thermal_alarm_out)
      else $error("alarm missed for remote 1");
   alarm_rd2_a: assert property (@(posedge i_clk) disable iff (!s_q.live)
      (i_temp_rd2 > s_q.crit2) |=> o_thermal_alarm_out)
      else $error("alarm missed for remote 2");
   alarm_quiet_a: assert property (@(posedge i_clk) disable iff (!s_q.live)
      (i_temp_rd1 <= s_q.crit1 && i_temp_rd2 <= s_q.crit2) |=> !o_thermal_alarm_out)
      else $error("alarm without exceeded limit");
   crit_write_a: assert property (@(posedge i_clk) disable iff (!s_q.live)
      (i_wr && sel[0]) |=> s_q.crit1 == $past(i_wdata))
      else $error("critical limit write lost");
   crit2_write_a: assert property (@(posedge i_clk) disable iff (!s_q.live)
      (i_wr && sel[1]) |=> s_q.crit2 == $past(i_wdata))
      else $error("remote 2 critical limit write lost");
   crit_read_a: assert property (@(posedge i_clk) disable iff (!s_q.live)
      sel[1] |=> o_rdata == $past(s_q.crit2))
      else $error("critical limit readback wrong");
   crit1_read_a: assert property (@(posedge i_clk) disable iff (!s_q.live)
      sel[0] |=> o_rdata == $past(s_q.crit1))
      else $error("remote 1 critical limit readback wrong");
   int_start_a: assert property (@(posedge i_clk) disable iff (!s_q.live)
      (i_temp_int > s_q.start_int) |=> o_fan_start_int)
      else $error("internal fan start missed");
   int_idle_a: assert property (@(posedge i_clk) disable iff (!s_q.live)
      (i_temp_int <= s_q.start_int) |=> !o_fan_start_int)
      else $error("internal fan start without exceeded value");
   int_write_a: assert property (@(posedge i_clk) disable iff (!s_q.live)
      (i_wr && sel[2]) |=> s_q.start_int == $past(i_wdata))
      else $error("internal fan start write lost");
   int_read_a: assert property (@(posedge i_clk) disable iff (!s_q.live)
      sel[2] |=> o_rdata == $past(s_q.start_int))
      else $error("internal fan start readback wrong");
   rd1_fan_a: assert property (@(posedge i_clk) disable iff (!s_q.live)
      (i_temp_rd1 > s_q.start_rd1) |=> o_fan_start_rd1)
      else $error("remote 1 fan start missed");
   rd1_idle_a: assert property (@(posedge i_clk) disable iff (!s_q.live)
      (i_temp_rd1 <= s_q.start_rd1) |=> !o_fan_start_rd1)
      else $error("remote 1 fan start without exceeded value");
   rd1_write_a: assert property (@(posedge i_clk) disable iff (!s_q.live)
      (i_wr && sel[3]) |=> s_q.start_rd1 == $past(i_wdata))
      else $error("remote 1 fan start write lost");
   rd2_fan_a: assert property (@(posedge i_clk) disable iff (!s_q.live)
      (i_temp_rd2 > s_q.start_rd2) |=> o_fan_start_rd2)
      else $error("remote 2 fan start missed");
   rd2_idle_a: assert property (@(posedge i_clk) disable iff (!s_q.live)
      (i_temp_rd2 <= s_q.start_rd2) |=> !o_fan_start_rd2)
      else $error("remote 2 fan start without exceeded value");
   rd2_start_a: assert property (@(posedge i_clk) disable iff (!s_q.live)
      (i_wr && sel[4]) |=> s_q.start_rd2 == $past(i_wdata))
      else $error("remote 2 fan start write lost");
   rd2_read_a: assert property (@(posedge i_clk) disable iff (!s_q.live)
      sel[4] |=> o_rdata == $past(s_q.start_rd2))
      else $error("remote 2 fan start readback wrong");
   regs_hold_a: assert property (@(posedge i_clk) disable iff (!s_q.live)
      !(i_wr && sel != 5'h00)
      |=> $stable({s_q.crit1, s_q.crit2, s_q.start_int, s_q.start_rd1, s_q.start_rd2}))
      else $error("register changed without a write");
   hit_read_a: assert property (@(posedge i_clk) disable iff (!s_q.live)
      (sel != 5'h00) |=> o_hit)
      else $error("mapped offset not flagged");
   miss_read_a: assert property (@(posedge i_clk) disable iff (!s_q.live)
      (sel == 5'h00) |=> (o_rdata == 8'h00 && !o_hit))
      else $error("unmapped offset not read as zero");
   crit_reset_a: assert property (@(posedge i_clk)
      $rose(rst_n) |-> (s_q.crit1 == ttr_pkg::RST_CRIT && s_q.crit2 == ttr_pkg::RST_CRIT))
      else $error("critical limit reset wrong");
   reset_vals_a: assert property (@(posedge i_clk)
      $rose(rst_n) |-> s_q.start_int == ttr_pkg::RST_INT_START)
      else $error("internal fan start reset wrong");
   rem_reset_a: assert property (@(posedge i_clk)
      $rose(rst_n) |-> (s_q.start_rd1 == ttr_pkg::RST_REM_START
                        && s_q.start_rd2 == ttr_pkg::RST_REM_START))
      else $error("remote fan start reset wrong");
endmodule

// >>> ttr_host.sv
// Purpose: host model driving the threshold register port
// Assumes: requests launched just after a rising edge
// Notes:   write strobe held exactly one cycle, address left standing
`timescale 1ns/1ps
module ttr_host (
   // clock
   input  wire logic       i_clk,
   // register port
   output logic      [7:0] o_addr  = 8'h00,
   output logic            o_wr    = 1'b0,
   output logic      [7:0] o_wdata = 8'h00
);
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      o_addr  <= a;
      o_wr    <= 1'b1;
      o_wdata <= d;
      @(posedge i_clk);
      o_wr    <= 1'b0;
      o_wdata <= ~d;
   endtask
   // read data lands one edge after the addressing edge
   task automatic sel(input logic [7:0] a);
      @(posedge i_clk);
      o_addr <= a;
      @(posedge i_clk);
   endtask
endmodule

// >>> ttr_regs_bench.sv
// Purpose: self-checking bench for ttr_regs against an integer model
// Assumes: host model owns the register port, bench owns the readings
// Notes:   limits probed at equal and one above, unmapped 0dh and 13h
`timescale 1ns/1ps
module ttr_regs_bench;
   logic       clk, rst_n, wr, hit, alarm, f0, f1, f2;
   logic [7:0] addr, wdata, rdata, t0, t1, t2, lo;
   int         n_fail, compares, cyc;
   int         mdl [5] = '{8'h50, 8'h50, 8'h28, 8'h40, 8'h40};
   ttr_host u_host (.i_clk(clk), .o_addr(addr), .o_wr(wr), .o_wdata(wdata));
   ttr_regs u_dut (.i_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wr(wr),
      .i_wdata(wdata), .o_rdata(rdata), .o_hit(hit), .i_temp_int(t0),
      .i_temp_rd1(t1), .i_temp_rd2(t2), .o_thermal_alarm_out(alarm),
      .o_fan_start_int(f0), .o_fan_start_rd1(f1), .o_fan_start_rd2(f2));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [7:0] a);
      u_host.sel(a);
      #1;
      if (a >= 8'h0e && a <= 8'h12)
         chk({hit, rdata}, {1'b1, 8'(mdl[a - 8'h0e])});
      else
         chk({hit, rdata}, 9'h000);
   endtask
   // outputs lag the readings by one registered cycle
   task automatic temps(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
      @(posedge clk);
      t0 <= a;
      t1 <= b;
      t2 <= c;
      @(posedge clk);
      #1;
      chk({5'h00, alarm, f2, f1, f0},
          {5'h00, b > mdl[0] || c > mdl[1], c > mdl[4], b > mdl[3], a > mdl[2]});
   endtask
   task automatic give_verdict;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         give_verdict();
      end
   end
   initial begin
      rst_n = 1'b0;
      t0 = 8'h00;
      t1 = 8'h00;
      t2 = 8'h00;
      void'($urandom(12217));
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      for (int i = 8'h0d; i <= 8'h13; i++) rd(8'(i));
      $display("test reset values done");
      for (int i = 8'h0d; i <= 8'h13; i++) begin
         lo = 8'($urandom);
         u_host.wr(8'(i), lo);
         if (i >= 8'h0e && i <= 8'h12) mdl[i - 8'h0e] = lo;
      end
      for (int i = 8'h0d; i <= 8'h13; i++) rd(8'(i));
      $display("test write readback done");
      for (int k = 0; k < 40; k++) begin
         lo = 8'($urandom);
         u_host.wr(8'h0e + 8'(k % 5), lo);
         mdl[k % 5] = lo;
         temps(lo, lo, lo);
         temps(lo + 8'h01, lo + 8'h01, 8'h00);
         temps(8'($urandom), 8'h00, lo + 8'h01);
      end
      $display("test threshold compare done");
      // reset in mid-run must bring every limit back to its default
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      mdl = '{8'h50, 8'h50, 8'h28, 8'h40, 8'h40};
      for (int i = 8'h0d; i <= 8'h13; i++) rd(8'(i));
      temps(8'h29, 8'h51, 8'h41);
      $display("test mid-run reset done");
      give_verdict();
   end
endmodule
